/* File: verilog/kbd_poll_pkg.sv */
// Purpose: shared constants and carriers for the keyboard poll interface
// Assumes: 250 MHz system clock
// Notes:   times are kept in their own units, cycle counts derived here
package kbd_poll_pkg;

    // ------------------------------------------------------------
    // bus widths and FIFO depth
    // ------------------------------------------------------------
    localparam int unsigned KEY_W   = 8;
    localparam int unsigned ADDR_W  = 14;
    localparam int unsigned FIFO_DEPTH = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned REPEAT_DELAY_MS = 500;
    localparam int unsigned REPEAT_CYCLES   = REPEAT_DELAY_MS * 1000 * CLK_MHZ;
    localparam int unsigned CLICK_NS        = 100;
    localparam int unsigned CLICK_CYCLES    = CLICK_NS * CLK_MHZ / 1000;
    localparam int unsigned BEEP_HALF_NS    = 200;
    localparam int unsigned BEEP_HALF_CYCLES = BEEP_HALF_NS * CLK_MHZ / 1000;

    // ------------------------------------------------------------
    // reset values and identity
    // ------------------------------------------------------------
    localparam logic [KEY_W-1:0] CARD_ADDR_DEFAULT = 8'h5A; // arbitrary value
    localparam logic [KEY_W-1:0] DATA_RESET        = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic             valid;
        logic [KEY_W-1:0] data;
    } in_bus_s;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_CLAIM  = 2'b01,
        ST_SELECT = 2'b11
    } sel_state_e;

endpackage

/* File: verilog/kbd_fifo.sv */
// Purpose: small valid/ready FIFO for key codes
// Assumes: single clock, depth a power of two
// Notes:   full and empty come from pointer difference
`timescale 1ns/1ns
module kbd_fifo
    import kbd_poll_pkg::*;
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_q;
    logic [PW:0]      rd_q;
    wire              empty = (wr_q == rd_q);
    wire              full  = (wr_q[PW-1:0] == rd_q[PW-1:0]) && (wr_q[PW] != rd_q[PW]);
    wire              push  = i_in_valid && !full;
    wire              pop   = i_out_ready && !empty;

    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = mem[rd_q[PW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_q[PW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (PW+1)'(push);
            rd_q <= rd_q + (PW+1)'(pop);
        end
    end
endmodule

/* File: verilog/kbd_poll_if.sv */
// Purpose: keyboard interface on the daisy-chained poll bus
// Assumes: poll and read commands are one-cycle pulses in this clock, beep request is a held level;
//          encoder pins are asynchronous and are synchronised here
// Notes:   key codes pass a 4-word FIFO; encoder is released by the data read
`timescale 1ns/1ns
module kbd_poll_if
    import kbd_poll_pkg::*;
#(
    parameter int unsigned REPEAT_CNT = REPEAT_CYCLES,
    parameter logic [KEY_W-1:0] CARD_ADDR = CARD_ADDR_DEFAULT
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_key_data_strobe_n,
    input  wire logic [KEY_W-1:0]  i_key_code_bus,
    input  wire logic              i_key_held,
    input  wire logic              i_poll_in,
    input  wire logic              i_data_read_cmd,
    input  wire logic              i_beep_req,
    input  wire logic [ADDR_W-1:0] i_memory_address_bus,
    output logic                   o_poll_out,
    output in_bus_s                o_in_bus,
    output logic                   o_release_n,
    output logic                   o_repeat_request,
    output logic                   o_speaker_drive
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] strb_meta_q;
    logic [2:0] strb_sync_q;
    logic [KEY_W-1:0] code_meta_q;
    logic [KEY_W-1:0] code_sync_q;
    logic strb_d1_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strb_meta_q <= '0;
            strb_sync_q <= '0;
            code_meta_q <= DATA_RESET;
            code_sync_q <= DATA_RESET;
            strb_d1_q   <= 1'b0;
        end else begin
            strb_meta_q <= {i_beep_req, i_key_held, !i_key_data_strobe_n};
            strb_sync_q <= strb_meta_q;
            code_meta_q <= i_key_code_bus;
            code_sync_q <= code_meta_q;
            strb_d1_q   <= strb_sync_q[0];
        end
    end

    wire strobe_s = strb_sync_q[0];
    wire held_s   = strb_sync_q[1];
    wire beep_s   = strb_sync_q[2];
    // code is taken one cycle after the strobe is seen so data has settled
    wire strobe_rise = strobe_s && !strb_d1_q;

    // ------------------------------------------------------------
    // key buffer
    // ------------------------------------------------------------
    logic             f_in_ready;
    logic             f_out_valid;
    logic [KEY_W-1:0] f_out_data;
    logic             rel_q;
    logic             pend_q;
    wire              pop;

    // a push waits pending while the FIFO is full; a new strobe then merges with it and the bus code at push time is stored
    wire push = pend_q && f_in_ready;

    kbd_fifo #(.WIDTH(KEY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (push),
        .o_in_ready  (f_in_ready),
        .i_in_data   (code_sync_q),
        .o_out_valid (f_out_valid),
        .i_out_ready (pop),
        .o_out_data  (f_out_data)
    );

    // ------------------------------------------------------------
    // poll / select
    // ------------------------------------------------------------
    sel_state_e st_q;
    sel_state_e st_d;
    wire claim    = i_poll_in && f_out_valid && (st_q == ST_IDLE);
    wire rd_sel   = i_data_read_cmd && (st_q == ST_SELECT);
    assign pop    = rd_sel;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE:   if (claim) st_d = ST_CLAIM;
            ST_CLAIM:  st_d = ST_SELECT;
            ST_SELECT: if (i_data_read_cmd) st_d = ST_IDLE;
            default:   st_d = ST_IDLE;
        endcase
    end

    wire in_bus_valid_d = claim || rd_sel;
    wire [KEY_W-1:0] in_bus_data_d = claim ? CARD_ADDR :
                                     rd_sel ? f_out_data : DATA_RESET;

    // ------------------------------------------------------------
    // repeat, click, beep
    // ------------------------------------------------------------
    logic [31:0] rpt_cnt_q;
    logic [7:0]  click_q;
    logic [7:0]  beep_cnt_q;
    logic        tone_q;
    wire rpt_done = (rpt_cnt_q == REPEAT_CNT);
    // counter runs 0 to half-1 so each tone phase lasts exactly the half period
    wire beep_wrap = (beep_cnt_q == 8'(BEEP_HALF_CYCLES - 1));
    wire speaker_d = (click_q != '0) || (beep_s && tone_q);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q             <= ST_IDLE;
            o_poll_out       <= 1'b0;
            o_in_bus         <= '0;
            o_release_n      <= 1'b1;
            o_repeat_request <= 1'b0;
            o_speaker_drive  <= 1'b0;
            pend_q           <= 1'b0;
            rel_q            <= 1'b0;
            rpt_cnt_q        <= '0;
            click_q          <= '0;
            beep_cnt_q       <= '0;
            tone_q           <= 1'b0;
        end else begin
            st_q        <= st_d;
            o_poll_out  <= i_poll_in && !claim;
            o_in_bus    <= {in_bus_valid_d, in_bus_data_d};
            pend_q      <= (pend_q && !push) || strobe_rise;
            rel_q       <= rd_sel;
            o_release_n <= !rel_q;
            rpt_cnt_q   <= !held_s ? '0 : (rpt_done ? rpt_cnt_q : rpt_cnt_q + 32'd1);
            o_repeat_request <= held_s && rpt_done;
            click_q     <= rd_sel ? 8'(CLICK_CYCLES) :
                           (click_q != '0 ? click_q - 8'h01 : click_q);
            beep_cnt_q  <= beep_wrap ? 8'h00 : beep_cnt_q + 8'h01;
            tone_q      <= beep_wrap ? !tone_q : tone_q;
            o_speaker_drive <= speaker_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_claim;
        i_poll_in && f_out_valid && st_q == ST_IDLE;
    endsequence

    sequence s_release_pulse;
        o_release_n ##1 !o_release_n ##1 o_release_n;
    endsequence

    a_poll_absorbed: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_claim |=> !o_poll_out) else $error("claimed poll passed on");
    a_claim_addr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_claim |=> o_in_bus.valid && o_in_bus.data == CARD_ADDR ##1 st_q == ST_SELECT)
        else $error("claim did not drive address");
    a_poll_pass: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_poll_in && !f_out_valid) |=> o_poll_out) else $error("poll not passed");
    a_read_data: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        rd_sel |=> o_in_bus.valid && o_in_bus.data == $past(f_out_data) && st_q == ST_IDLE)
        else $error("read did not drive key code");
    a_release_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        rd_sel |=> s_release_pulse)
        else $error("release pulse wrong");
    a_click_fire: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        rd_sel |-> ##2 o_speaker_drive) else $error("no click");
    a_repeat_held: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_repeat_request |-> $past(held_s)) else $error("repeat without held key");
    a_idle_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_data_read_cmd && st_q == ST_IDLE && !i_poll_in) |=> !o_in_bus.valid)
        else $error("bus driven while unselected");
endmodule

/* File: sim/cpu_model.sv */
// Purpose: processor side of the poll bus, issues poll and data-read commands
// Assumes: commands are one-cycle pulses launched on the falling edge
// Notes:   answers are caught over a short window, which also spaces commands
`timescale 1ns/1ns
module cpu_model
    import kbd_poll_pkg::*;
(
    input  wire logic    i_clk,
    input  wire in_bus_s i_in_bus,
    input  wire logic    i_poll_out,
    input  wire logic    i_release_n,
    output logic         o_poll,
    output logic         o_data_read_cmd
);
    initial begin
        o_poll = 1'h0;
        o_data_read_cmd = 1'h0;
    end

    // one command, then four sampled cycles; the window keeps read six cycles past poll
    task automatic issue(input logic is_read, output logic got,
                         output logic [KEY_W-1:0] data, output logic passed,
                         output logic rel);
        got = 1'h0;
        data = 8'h00;
        passed = 1'h0;
        rel = 1'h0;
        @(negedge i_clk);
        if (is_read) begin
            o_data_read_cmd = 1'h1;
        end else begin
            o_poll = 1'h1;
        end
        @(negedge i_clk);
        o_poll = 1'h0;
        o_data_read_cmd = 1'h0;
        repeat (4) begin
            if (i_in_bus.valid === 1'h1) begin
                got = 1'h1;
                data = i_in_bus.data;
            end
            if (i_poll_out === 1'h1) begin
                passed = 1'h1;
            end
            if (i_release_n === 1'h0) begin
                rel = 1'h1;
            end
            @(negedge i_clk);
        end
    endtask
endmodule

/* File: sim/testbench.sv */
// Purpose: self-checking bench for the keyboard poll interface
// Assumes: bench plays the key encoder, cpu_model plays the processor
// Notes:   repeat delay shortened to 20 cycles so the hold test stays quick
`timescale 1ns/1ns
module testbench;
    import kbd_poll_pkg::*;
    localparam int unsigned REP = 20;
    logic             clk;
    logic             reset_n;
    logic             strobe_n;
    logic             held;
    logic             beep;
    logic             poll;
    logic             rd;
    logic             poll_out;
    logic             release_n;
    logic             rep;
    logic             spk;
    logic [KEY_W-1:0] code;
    in_bus_s          in_bus;
    int               bad_count = 0;
    int               n_compared = 0;
    int               spk_rises = 0;
    int               r0;
    logic             got;
    logic             passed;
    logic             rel;
    logic [KEY_W-1:0] data;

    kbd_poll_if #(.REPEAT_CNT(REP)) uut (.i_clk(clk), .i_reset_n(reset_n),
        .i_key_data_strobe_n(strobe_n), .i_key_code_bus(code), .i_key_held(held),
        .i_poll_in(poll), .i_data_read_cmd(rd), .i_beep_req(beep),
        .i_memory_address_bus(14'h0000), .o_poll_out(poll_out), .o_in_bus(in_bus),
        .o_release_n(release_n), .o_repeat_request(rep), .o_speaker_drive(spk));
    cpu_model cpu (.i_clk(clk), .i_in_bus(in_bus), .i_poll_out(poll_out),
        .i_release_n(release_n), .o_poll(poll), .o_data_read_cmd(rd));

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // one count per speaker pulse, so a click and a tone can be told apart
    always @(posedge spk) spk_rises++;

    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // encoder: code held steady while strobe is low, strobe lifted before next key
    task automatic key_in(input logic [KEY_W-1:0] c);
        @(negedge clk);
        code = c;
        strobe_n = 1'h0;
        repeat (8) @(negedge clk);
        strobe_n = 1'h1;
        repeat (2) @(negedge clk);
    endtask

    task automatic test_idle();
        r0 = spk_rises;
        cpu.issue(1'h0, got, data, passed, rel);
        check(passed === 1'h1 && got === 1'h0, "idle poll not passed on");
        cpu.issue(1'h1, got, data, passed, rel);
        check(got === 1'h0 && rel === 1'h0, "unselected read answered");
        check(spk_rises === r0, "unselected read clicked");
        $display("test idle done");
    endtask

    task automatic test_keys();
        key_in(8'h41);
        key_in(8'h42);
        for (int i = 0; i < 2; i++) begin
            cpu.issue(1'h0, got, data, passed, rel);
            check(passed === 1'h0, "claimed poll leaked downstream");
            check(got === 1'h1 && data === CARD_ADDR_DEFAULT, "no card address");
            r0 = spk_rises;
            cpu.issue(1'h1, got, data, passed, rel);
            check(got === 1'h1 && data === 8'h41 + i, "wrong key code");
            check(rel === 1'h1, "no encoder release");
            check(spk_rises === r0 + 1, "not one click");
            cpu.issue(1'h1, got, data, passed, rel);
            check(got === 1'h0, "still selected after read");
            repeat (30) @(negedge clk);
        end
        $display("test keys done");
    endtask

    task automatic test_beep();
        r0 = spk_rises;
        beep = 1'h1;
        repeat (250) @(negedge clk);
        beep = 1'h0;
        check(spk_rises - r0 >= 2, "no beep tone");
        repeat (120) @(negedge clk);
        $display("test beep done");
    endtask

    task automatic test_repeat();
        held = 1'h1;
        repeat (10) @(negedge clk);
        check(rep === 1'h0, "repeat too early");
        repeat (30) @(negedge clk);
        check(rep === 1'h1, "repeat missing");
        held = 1'h0;
        repeat (4) @(negedge clk);
        check(rep === 1'h0, "repeat after key up");
        held = 1'h1;
        key_in(8'h43);
        cpu.issue(1'h0, got, data, passed, rel);
        check(got === 1'h1 && data === CARD_ADDR_DEFAULT, "no claim before reset");
        repeat (10) @(negedge clk);
        check(rep === 1'h1, "repeat lost while held");
        reset_n = 1'h0;
        repeat (2) @(negedge clk);
        check(rep === 1'h0 && spk === 1'h0 && release_n === 1'h1, "reset state");
        check(in_bus.valid === 1'h0 && poll_out === 1'h0, "reset bus");
        held = 1'h0;
        reset_n = 1'h1;
        repeat (10) @(negedge clk);
        check(rep === 1'h0, "repeat after reset");
        $display("test repeat done");
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        summarize();
    end

    initial begin
        reset_n = 1'h0;
        strobe_n = 1'h1;
        held = 1'h0;
        beep = 1'h0;
        code = 8'h00;
        repeat (4) @(negedge clk);
        reset_n = 1'h1;
        repeat (2) @(negedge clk);
        test_idle();
        test_keys();
        test_beep();
        test_repeat();
        test_idle();
        summarize();
    end
endmodule
